// ==== cmsl_chan.sv ====
// Purpose: Command, configuration and framing of a serial channel
// Assumes: One clock at 50 MHz; line pins are asynchronous
// Notes:   Received words pass a two-entry buffer toward the user
`include "cmsl_regs.svh"

// Function
// - A command with only the assert bit set drives the ready line active.
// - A command with only the release bit set drives the ready line inactive.
// - A rising halt bit aborts every transfer (expansion variant only).
// - The type byte holds the protocol; 3 selects character mode.
// - Speed codes fe, ff, 00, 01, 02 give 300 to 4800 bits/s.
// - Code 03 gives 9600 bits/s and is the default speed.
// - Code 04 gives 38400; codes 05 and 07 need the expansion variant.
// - Format bit 8 picks eight data bits when 1, seven when 0.
// - Format bit 9 enables a parity bit when 1.
// - Format bit 10 picks odd parity when 1, even when 0.
// - Format bit 11 picks one stop bit when 1, two when 0.
// - Format bit 13 picks RS232 when 1, RS485 when 0.
// - Format bit 14 enables modem signals, only on expansion RS232.
// - On RS232 format bit 15 adds the RTS/CTS handshake.
// - On RS485 the handshake is off and only data lines are used.
module cmsl_chan #(
    parameter int unsigned CLK_HZ = `CMSL_CLK_HZ,
    parameter int CNT_W = `CMSL_CNT_W,
    parameter bit EXPANSION = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Command and configuration writes
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_data,
    input wire logic halt_wr,
    input wire logic [15:0] halt_data,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_type,
    input wire logic [15:0] cfg_line,
    // Register readback
    output logic [15:0] channel_command_word,
    output logic [15:0] output_halt_word,
    output logic [15:0] protocol_type_config,
    output logic [15:0] line_speed_format_config,
    output logic char_mode,
    // Transmit stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Receive stream
    output logic rx_valid,
    output cmsl_pkg::cmsl_rxw_s rx_word,
    input wire logic rx_ready,
    // Line pins
    input wire logic rxd,
    input wire logic cts,
    input wire logic dsr,
    input wire logic dcd,
    output logic txd,
    output logic rts,
    output logic dtr,
    output logic de
);
    import cmsl_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] bit_cycles(
        input logic [7:0] code);
        int unsigned baud;
        baud = `CMSL_BAUD_9600;
        case (code)
            `CMSL_SPD_300: baud = `CMSL_BAUD_300;
            `CMSL_SPD_600: baud = `CMSL_BAUD_600;
            `CMSL_SPD_1200: baud = `CMSL_BAUD_1200;
            `CMSL_SPD_2400: baud = `CMSL_BAUD_2400;
            `CMSL_SPD_4800: baud = `CMSL_BAUD_4800;
            `CMSL_SPD_38400: baud = `CMSL_BAUD_38400;
            `CMSL_SPD_57600: if (EXPANSION) baud = `CMSL_BAUD_57600;
            `CMSL_SPD_115200: if (EXPANSION) baud = `CMSL_BAUD_115200;
            default: baud = `CMSL_BAUD_9600;
        endcase
        return CNT_W'(CLK_HZ / baud);
    endfunction

    function automatic logic par_bit(input logic [7:0] d,
        input logic len8, input logic odd);
        return (^{len8 & d[7], d[6:0]}) ^ odd;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] pin_f;
    logic [3:0] next_pin_f;
    logic rxd_f;
    logic cts_f;
    logic dsr_f;
    logic dcd_f;

    always_comb begin
        next_pin_f = ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & pin_f);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sy1 <= `CMSL_PIN_RST;
            sy2 <= `CMSL_PIN_RST;
            sy3 <= `CMSL_PIN_RST;
            pin_f <= `CMSL_PIN_RST;
        end else begin
            sy1 <= {dcd, dsr, cts, rxd};
            sy2 <= sy1;
            sy3 <= sy2;
            pin_f <= next_pin_f;
        end
    end

    assign rxd_f = pin_f[0];
    assign cts_f = pin_f[1];
    assign dsr_f = pin_f[2];
    assign dcd_f = pin_f[3];

    // ------------------------------------------------------------
    // Command and configuration registers
    // ------------------------------------------------------------
    logic [15:0] next_cmd;
    logic [15:0] next_halt;
    logic [15:0] next_type;
    logic [15:0] next_line;
    logic next_dtr;
    logic next_char_mode;
    logic halt_prev;
    logic halt_rise;
    cmsl_fmt_s fmt;
    logic [CNT_W-1:0] bitc;

    always_comb begin
        next_cmd = channel_command_word;
        next_halt = output_halt_word;
        next_type = protocol_type_config;
        next_line = line_speed_format_config;
        next_dtr = dtr;
        if (cmd_wr) begin
            next_cmd = cmd_data;
            if (cmd_data[`CMSL_DTR_ON_BIT] &&
                !cmd_data[`CMSL_DTR_OFF_BIT]) begin
                next_dtr = 1'b1;
            end else if (cmd_data[`CMSL_DTR_OFF_BIT] &&
                !cmd_data[`CMSL_DTR_ON_BIT]) begin
                next_dtr = 1'b0;
            end
        end
        if (halt_wr) begin
            next_halt = halt_data;
        end
        if (cfg_wr) begin
            next_type = cfg_type;
            next_line = cfg_line;
        end
        next_char_mode = next_type[7:0] == `CMSL_TYPE_CHAR;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            channel_command_word <= `CMSL_CMD_RST;
            output_halt_word <= `CMSL_HALT_RST;
            protocol_type_config <= `CMSL_TYPE_RST;
            line_speed_format_config <= `CMSL_LINE_RST;
            char_mode <= 1'b1;
            dtr <= 1'b0;
            halt_prev <= 1'b0;
        end else begin
            channel_command_word <= next_cmd;
            output_halt_word <= next_halt;
            protocol_type_config <= next_type;
            line_speed_format_config <= next_line;
            char_mode <= next_char_mode;
            dtr <= next_dtr;
            halt_prev <= output_halt_word[`CMSL_HALT_BIT];
        end
    end

    // Abort fires once on the rising edge of the halt bit
    assign halt_rise = EXPANSION && !halt_prev &&
        output_halt_word[`CMSL_HALT_BIT];

    always_comb begin
        fmt.len8 = line_speed_format_config[`CMSL_LEN8_BIT];
        fmt.par_en = line_speed_format_config[`CMSL_PAR_EN_BIT];
        fmt.par_odd = line_speed_format_config[`CMSL_PAR_ODD_BIT];
        fmt.stop1 = line_speed_format_config[`CMSL_STOP1_BIT];
        fmt.rs232 = line_speed_format_config[`CMSL_RS232_BIT];
        fmt.modem = EXPANSION && fmt.rs232 &&
            line_speed_format_config[`CMSL_MODEM_BIT];
        fmt.flow = fmt.rs232 &&
            line_speed_format_config[`CMSL_FLOW_BIT];
        bitc = bit_cycles(line_speed_format_config[7:0]);
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    cmsl_ser_e tx_st;
    cmsl_ser_e next_tx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] next_tx_cnt;
    logic [2:0] tx_bitn;
    logic [2:0] next_tx_bitn;
    logic [7:0] tx_sh;
    logic [7:0] next_tx_sh;
    logic tx_par;
    logic next_tx_par;
    logic tx_stop2;
    logic next_tx_stop2;
    logic next_txd;
    logic next_tx_ready;
    logic next_de;
    logic tx_go;
    logic tx_tick;

    always_comb begin
        next_tx_st = tx_st;
        next_tx_cnt = tx_cnt - 1'b1;
        next_tx_bitn = tx_bitn;
        next_tx_sh = tx_sh;
        next_tx_par = tx_par;
        next_tx_stop2 = tx_stop2;
        next_txd = txd;
        tx_tick = tx_cnt == '0;
        // Handshake and modem lines hold the next character back
        tx_go = char_mode && !halt_rise &&
            !(fmt.flow && !cts_f) &&
            !(fmt.modem && !dsr_f);
        unique case (tx_st)
            CMSL_IDLE: begin
                next_tx_cnt = tx_cnt;
                next_txd = 1'b1;
                if (tx_valid && tx_ready) begin
                    next_tx_st = CMSL_START;
                    next_tx_cnt = bitc - 1'b1;
                    next_tx_sh = tx_data;
                    next_tx_bitn = '0;
                    next_tx_par = par_bit(tx_data, fmt.len8,
                        fmt.par_odd);
                    next_tx_stop2 = !fmt.stop1;
                    next_txd = 1'b0;
                end
            end
            CMSL_START: begin
                if (tx_tick) begin
                    next_tx_st = CMSL_DATA;
                    next_tx_cnt = bitc - 1'b1;
                    next_txd = tx_sh[0];
                end
            end
            CMSL_DATA: begin
                if (tx_tick) begin
                    next_tx_cnt = bitc - 1'b1;
                    next_tx_sh = {1'b0, tx_sh[7:1]};
                    next_tx_bitn = tx_bitn + 1'b1;
                    next_txd = tx_sh[1];
                    if (tx_bitn == {2'b11, fmt.len8}) begin
                        if (fmt.par_en) begin
                            next_tx_st = CMSL_PAR;
                            next_txd = tx_par;
                        end else begin
                            next_tx_st = CMSL_STOP;
                            next_txd = 1'b1;
                        end
                    end
                end
            end
            CMSL_PAR: begin
                if (tx_tick) begin
                    next_tx_st = CMSL_STOP;
                    next_tx_cnt = bitc - 1'b1;
                    next_txd = 1'b1;
                end
            end
            CMSL_STOP: begin
                if (tx_tick) begin
                    next_tx_cnt = bitc - 1'b1;
                    if (tx_stop2) begin
                        next_tx_stop2 = 1'b0;
                    end else begin
                        next_tx_st = CMSL_IDLE;
                    end
                end
            end
            default: begin
                next_tx_st = CMSL_IDLE;
            end
        endcase
        if (halt_rise) begin
            next_tx_st = CMSL_IDLE;
            next_txd = 1'b1;
        end
        next_tx_ready = next_tx_st == CMSL_IDLE && tx_go &&
            !(tx_valid && tx_ready);
        // RS485 driver is enabled only while a frame is on the line
        next_de = !fmt.rs232 && next_tx_st != CMSL_IDLE;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_st <= CMSL_IDLE;
            tx_cnt <= '0;
            tx_bitn <= '0;
            tx_sh <= '0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            txd <= 1'b1;
            tx_ready <= 1'b0;
            de <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tx_cnt <= next_tx_cnt;
            tx_bitn <= next_tx_bitn;
            tx_sh <= next_tx_sh;
            tx_par <= next_tx_par;
            tx_stop2 <= next_tx_stop2;
            txd <= next_txd;
            tx_ready <= next_tx_ready;
            de <= next_de;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    cmsl_ser_e rx_st;
    cmsl_ser_e next_rx_st;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] next_rx_cnt;
    logic [2:0] rx_bitn;
    logic [2:0] next_rx_bitn;
    logic [7:0] rx_sh;
    logic [7:0] next_rx_sh;
    logic rx_perr;
    logic next_rx_perr;
    logic rxw_valid;
    logic next_rxw_valid;
    cmsl_rxw_s rxw;
    cmsl_rxw_s next_rxw;
    logic next_rts;
    logic buf_ready;
    logic rx_tick;

    always_comb begin
        next_rx_st = rx_st;
        next_rx_cnt = rx_cnt - 1'b1;
        next_rx_bitn = rx_bitn;
        next_rx_sh = rx_sh;
        next_rx_perr = rx_perr;
        next_rxw_valid = 1'b0;
        next_rxw = rxw;
        rx_tick = rx_cnt == '0;
        unique case (rx_st)
            CMSL_IDLE: begin
                next_rx_cnt = rx_cnt;
                if (char_mode && !rxd_f &&
                    !(fmt.modem && !dcd_f)) begin
                    next_rx_st = CMSL_START;
                    next_rx_cnt = bitc >> 1;
                end
            end
            CMSL_START: begin
                // Mid-bit check rejects glitches as start bits
                if (rx_tick) begin
                    next_rx_st = rxd_f ? CMSL_IDLE : CMSL_DATA;
                    next_rx_cnt = bitc - 1'b1;
                    next_rx_bitn = '0;
                    next_rx_sh = '0;
                    next_rx_perr = 1'b0;
                end
            end
            CMSL_DATA: begin
                if (rx_tick) begin
                    next_rx_cnt = bitc - 1'b1;
                    next_rx_sh[rx_bitn] = rxd_f;
                    next_rx_bitn = rx_bitn + 1'b1;
                    if (rx_bitn == {2'b11, fmt.len8}) begin
                        next_rx_st = fmt.par_en ? CMSL_PAR
                            : CMSL_STOP;
                    end
                end
            end
            CMSL_PAR: begin
                if (rx_tick) begin
                    next_rx_st = CMSL_STOP;
                    next_rx_cnt = bitc - 1'b1;
                    next_rx_perr = rxd_f != par_bit(rx_sh, fmt.len8,
                        fmt.par_odd);
                end
            end
            CMSL_STOP: begin
                if (rx_tick) begin
                    next_rx_st = CMSL_IDLE;
                    next_rxw_valid = 1'b1;
                    next_rxw.data = rx_sh;
                    next_rxw.par_err = rx_perr;
                    next_rxw.frm_err = !rxd_f;
                end
            end
            default: begin
                next_rx_st = CMSL_IDLE;
            end
        endcase
        if (halt_rise) begin
            next_rx_st = CMSL_IDLE;
            next_rxw_valid = 1'b0;
        end
        // RTS is raised only while the buffer can take a word
        next_rts = fmt.flow && buf_ready;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_st <= CMSL_IDLE;
            rx_cnt <= '0;
            rx_bitn <= '0;
            rx_sh <= '0;
            rx_perr <= 1'b0;
            rxw_valid <= 1'b0;
            rxw <= '0;
            rts <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            rx_cnt <= next_rx_cnt;
            rx_bitn <= next_rx_bitn;
            rx_sh <= next_rx_sh;
            rx_perr <= next_rx_perr;
            rxw_valid <= next_rxw_valid;
            rxw <= next_rxw;
            rts <= next_rts;
        end
    end

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    cmsl_buf #(
        .W($bits(cmsl_rxw_s))
    ) u_rx_buf (
        .clk(clk),
        .nrst(nrst),
        .flush(halt_rise),
        .in_valid(rxw_valid),
        .in_data(rxw),
        .in_ready(buf_ready),
        .out_valid(rx_valid),
        .out_data(rx_word),
        .out_ready(rx_ready)
    );

endmodule

// ==== cmsl_regs.svh ====
// Purpose: Bit positions, codes, reset values and timing of the channel
// Assumes: Included by the channel module
// Notes:   Definitions only
`ifndef CMSL_REGS_SVH
`define CMSL_REGS_SVH

// ----------------------------------------------------------------
// Command and output words
// ----------------------------------------------------------------
`define CMSL_DTR_ON_BIT 8
`define CMSL_DTR_OFF_BIT 9
`define CMSL_HALT_BIT 0

// ----------------------------------------------------------------
// Configuration words
// ----------------------------------------------------------------
`define CMSL_TYPE_CHAR 8'h03
`define CMSL_LEN8_BIT 8
`define CMSL_PAR_EN_BIT 9
`define CMSL_PAR_ODD_BIT 10
`define CMSL_STOP1_BIT 11
`define CMSL_RS232_BIT 13
`define CMSL_MODEM_BIT 14
`define CMSL_FLOW_BIT 15

// ----------------------------------------------------------------
// Speed codes and rates in bits/s
// ----------------------------------------------------------------
`define CMSL_SPD_300 8'hfe
`define CMSL_SPD_600 8'hff
`define CMSL_SPD_1200 8'h00
`define CMSL_SPD_2400 8'h01
`define CMSL_SPD_4800 8'h02
`define CMSL_SPD_9600 8'h03
`define CMSL_SPD_38400 8'h04
`define CMSL_SPD_57600 8'h05
`define CMSL_SPD_115200 8'h07
`define CMSL_BAUD_300 300
`define CMSL_BAUD_600 600
`define CMSL_BAUD_1200 1200
`define CMSL_BAUD_2400 2400
`define CMSL_BAUD_4800 4800
`define CMSL_BAUD_9600 9600
`define CMSL_BAUD_38400 38400
`define CMSL_BAUD_57600 57600
`define CMSL_BAUD_115200 115200

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CMSL_CMD_RST 16'h0000
`define CMSL_HALT_RST 16'h0000
`define CMSL_TYPE_RST 16'h0003
`define CMSL_LINE_RST 16'h2903
`define CMSL_PIN_RST 4'h1
`define CMSL_CLK_HZ 50000000
`define CMSL_CNT_W 18

`endif

// ==== cmsl_pkg.sv ====
// Purpose: Types shared by the serial channel modules
// Assumes: Nothing beyond the constants header
// Notes:   State codes follow a Gray path idle-start-data-parity-stop
package cmsl_pkg;

    // ------------------------------------------------------------
    // Frame sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMSL_IDLE = 3'h0,
        CMSL_START = 3'h1,
        CMSL_DATA = 3'h3,
        CMSL_PAR = 3'h2,
        CMSL_STOP = 3'h6
    } cmsl_ser_e;

    // ------------------------------------------------------------
    // Decoded character format and received word
    // ------------------------------------------------------------
    typedef struct packed {
        logic len8;
        logic par_en;
        logic par_odd;
        logic stop1;
        logic rs232;
        logic modem;
        logic flow;
    } cmsl_fmt_s;

    typedef struct packed {
        logic [7:0] data;
        logic par_err;
        logic frm_err;
    } cmsl_rxw_s;

endpackage

// ==== cmsl_buf.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock; flush drops both entries
// Notes:   All outputs are registers
module cmsl_buf #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic spare_valid;
    logic [W-1:0] spare_data;
    logic next_out_valid;
    logic [W-1:0] next_out_data;
    logic next_spare_valid;
    logic [W-1:0] next_spare_data;
    logic accept;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        accept = in_valid && in_ready;
        next_out_valid = out_valid;
        next_out_data = out_data;
        next_spare_valid = spare_valid;
        next_spare_data = spare_data;
        if (!out_valid || out_ready) begin
            if (spare_valid) begin
                next_out_valid = 1'b1;
                next_out_data = spare_data;
                next_spare_valid = 1'b0;
            end else begin
                next_out_valid = accept;
                next_out_data = accept ? in_data : out_data;
            end
        end else if (accept) begin
            next_spare_valid = 1'b1;
            next_spare_data = in_data;
        end
        if (flush) begin
            next_out_valid = 1'b0;
            next_spare_valid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data <= '0;
            spare_valid <= 1'b0;
            spare_data <= '0;
            in_ready <= 1'b0;
        end else begin
            out_valid <= next_out_valid;
            out_data <= next_out_data;
            spare_valid <= next_spare_valid;
            spare_data <= next_spare_data;
            in_ready <= !next_spare_valid;
        end
    end

endmodule

// ==== cmsl_chan_sva.sv ====
// Purpose: Port checker for the serial channel
// Assumes: One clock domain
// Notes:   Bound to every channel instance
module cmsl_chan_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Writes
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_data,
    input wire logic halt_wr,
    input wire logic [15:0] halt_data,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_type,
    input wire logic [15:0] cfg_line,
    // Readback and pins
    input wire logic [15:0] output_halt_word,
    input wire logic [15:0] line_speed_format_config,
    input wire logic char_mode,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic cts,
    input wire logic txd,
    input wire logic dtr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic flow_on = line_speed_format_config[15]
        & line_speed_format_config[13];
    dtr_set_a:
        assert property (cmd_wr && cmd_data[9:8] == 2'h1 |=> dtr)
        else $error("dtr not set");
    dtr_clear_a:
        assert property (cmd_wr && cmd_data[9:8] == 2'h2 |=> !dtr)
        else $error("dtr not cleared");
    dtr_hold_a:
        assert property (cmd_wr && cmd_data[8] == cmd_data[9]
            |=> $stable(dtr)) else $error("dtr moved");
    halt_abort_a:
        assert property (halt_wr && halt_data[0] && !output_halt_word[0]
            |-> ##2 txd && !rx_valid) else $error("halt ignored");
    type_mode_a:
        assert property (cfg_wr |=> char_mode == ($past(cfg_type[7:0])
            == 8'h03)) else $error("mode wrong");
    line_word_a:
        assert property (cfg_wr |=> line_speed_format_config
            == $past(cfg_line)) else $error("line word wrong");
    tx_start_a:
        assert property (tx_valid && tx_ready |=> !txd && !tx_ready)
        else $error("no start bit");
    cts_gate_a:
        assert property ((flow_on && !cts) [*6] |=> !tx_ready)
        else $error("sent without cts");
    cover property ($rose(dtr));
    cover property (halt_wr && halt_data[0]);
    cover property (tx_valid && tx_ready);
endmodule

bind cmsl_chan cmsl_chan_sva chk (.*);

// ==== cmsl_remote.sv ====
// Purpose: Remote serial equipment on the line pins
// Assumes: Bit time of BITC clock cycles
// Notes:   Line idles high between frames
module cmsl_remote #(
    parameter int BITC = 120
) (
    // Clock and line pins
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'h1;
    task automatic send(input logic [11:0] fr, input int n);
        for (int i = 0; i < n; i++) begin
            rxd = fr[i];
            repeat (BITC) @(negedge clk);
        end
    endtask
    // Samples from the middle of the start bit
    task automatic grab(output logic [11:0] fr, input int n);
        fr = 12'hfff;
        @(negedge txd);
        repeat (BITC / 2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            fr[i] = txd;
            repeat (BITC) @(negedge clk);
        end
    endtask
endmodule

// ==== char_mode_serial_line_config_tb.sv ====
// Purpose: Self-checking bench for the serial channel
// Assumes: Bit time shortened through CLK_HZ
// Notes:   Ready line, mode, speeds, formats, halt, buffer
module char_mode_serial_line_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HZ = 1152000;
    logic clk = 1'h0, nrst = 1'h0, cmd_wr = 1'h0, halt_wr = 1'h0;
    logic cfg_wr = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0, cts = 1'h1;
    logic dsr = 1'h1, dcd = 1'h1, char_mode, tx_ready, rx_valid, rxd;
    logic txd, rts, dtr, de;
    logic [15:0] cmd_data = 16'h0, halt_data = 16'h0;
    logic [15:0] cfg_type = 16'h3, cfg_line = 16'h2903;
    logic [15:0] channel_command_word, output_halt_word;
    logic [15:0] protocol_type_config, line_speed_format_config;
    logic [7:0] tx_data = 8'h0;
    logic [11:0] f;
    cmsl_pkg::cmsl_rxw_s rx_word;
    int miscompares = 0, checks = 0, t;
    logic [15:0] dc [4] = '{16'h100, 16'h300, 16'h200, 16'h300};
    logic [15:0] fc [4] = '{16'h2903, 16'h2603, 16'h0b03, 16'ha903};
    logic [7:0] fd [4] = '{8'ha5, 8'h35, 8'h3c, 8'h5a};
    logic [7:0] sc [10] = '{8'hfe, 8'hff, 8'h0, 8'h1, 8'h2, 8'h3,
        8'h4, 8'h5, 8'h7, 8'h6};
    int br [10] = '{300, 600, 1200, 2400, 4800, 9600, 38400, 57600,
        115200, 9600};
    always #10 clk = ~clk;
    cmsl_chan #(.CLK_HZ(HZ)) dut (.*);
    cmsl_remote #(.BITC(HZ / 9600)) rem (.*);
    task automatic cmp(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] k, input logic [15:0] d);
        @(negedge clk);
        {cfg_wr, halt_wr, cmd_wr} = k;
        {cmd_data, halt_data, cfg_line} = {3{d}};
        @(negedge clk);
        {cfg_wr, halt_wr, cmd_wr} = 3'h0;
    endtask
    task automatic put(input logic [7:0] d);
        tx_data = d;
        tx_valid = 1'h1;
        @(posedge clk iff tx_ready);
        @(negedge clk);
        tx_valid = 1'h0;
    endtask
    function automatic logic [11:0] frame(input logic [15:0] c,
        input logic [7:0] d);
        logic [11:0] r;
        logic p;
        r = 12'hffe;
        p = c[10];
        for (int i = 0; i < 7 + c[8]; i++) begin
            r[i + 1] = d[i];
            p ^= d[i];
        end
        if (c[9])
            r[8 + c[8]] = p;
        return r;
    endfunction
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1'h1;
        for (int i = 0; i < 4; i++) begin
            wr(3'h1, dc[i]);
            cmp("dtr", 16'(i < 2), dtr);
        end
        cfg_type = 16'h5;
        wr(3'h4, 16'h2903);
        cmp("char mode", 16'h0, char_mode);
        cfg_type = 16'h3;
        $display("dtr and mode done");
        for (int i = 0; i < 10; i++) begin
            wr(3'h4, {8'h29, sc[i]});
            fork
                put(8'h01);
            join_none
            @(negedge txd);
            @(negedge clk);
            for (t = 0; txd === 1'h0; t++) @(negedge clk);
            cmp("bit time", 16'(HZ / br[i]), 16'(t));
            wr(3'h2, 16'h1);
            wr(3'h2, 16'h0);
            cmp("halted line", 16'h1, tx_ready);
        end
        $display("speed and halt done");
        for (int i = 0; i < 4; i++) begin
            wr(3'h4, fc[i]);
            t = 10 + fc[i][8] + fc[i][9] - fc[i][11];
            fork
                rem.grab(f, t);
            join_none
            put(fd[i]);
            cmp("de", 16'(!fc[i][13]), de);
            wait fork;
            cmp("frame", 16'(frame(fc[i], fd[i])),
                16'(f));
            cmp("tx ready", 16'h1, tx_ready);
            if (i == 3)
                cmp("rts", 16'h0, rts);
            rem.send(frame(fc[i], fd[i]), t);
        end
        cts = 1'h0;
        repeat (8) @(negedge clk);
        cmp("cts gate", 16'h0, tx_ready);
        {cts, dsr} = 2'h2;
        wr(3'h4, 16'h6903);
        repeat (8) @(negedge clk);
        cmp("dsr gate", 16'h0, tx_ready);
        rx_ready = 1'h1;
        for (int i = 0; i < 2; i++) begin
            while (rx_valid !== 1'h1)
                @(negedge clk);
            cmp("rx word", {fd[i], 2'h0}, rx_word);
            @(negedge clk);
        end
        cmp("rx drained", 16'h0, rx_valid);
        $display("format done");
        give_verdict;
    end
endmodule
